// *** design/fepd_top.sv ***
// command interpreter for block/chip erase, deep sleep and id reads
// assumes a serial host on select, clock and two data lines
`timescale 1ns/10ps
`include "fepd_defs.svh"
module fepd_top #(
  parameter int                NUM_BLOCKS        = 32,
  parameter int unsigned       ERASE_CYCLES      = `FEPD_MS_CYC(`FEPD_ERASE_CYCLE_TIME_MS),
  parameter int unsigned       FULL_ERASE_CYCLES = `FEPD_MS_CYC(`FEPD_FULL_ERASE_TIME_MS),
  // identity values below are arbitrary
  parameter logic [7:0]        MAKER_ID          = 8'h5A,
  parameter logic [7:0]        PART_ID           = 8'h3C
) (
  input  wire logic            clk_sys_in,
  input  wire logic            nrst_in,
  input  wire logic            sck_in,
  input  wire logic            cs_n_in,
  input  wire logic            io0_in,
  output logic                 io0_out,
  output logic                 io0_oe_out,
  input  wire logic            io1_in,
  output logic                 io1_out,
  output logic                 io1_oe_out,
  input  wire logic [4:0]      protect_level_bits_in,
  output logic                 write_in_progress_flag_out,
  output logic                 write_latch_flag_out,
  output logic                 sleep_mode_out,
  output logic                 erase_go_out,
  output logic                 erase_chip_out,
  output logic [4:0]           erase_block_out
);
  import fepd_pkg::*;

  localparam logic [31:0] SLEEP_ENTRY_CYC =
    32'(`FEPD_CEIL_CYC(`FEPD_SLEEP_ENTRY_DELAY_NS));
  localparam logic [31:0] WAKE_CYC =
    32'(`FEPD_CEIL_CYC(`FEPD_WAKE_DELAY_NS));
  localparam logic [31:0] WAKE_ID_CYC =
    32'(`FEPD_CEIL_CYC(`FEPD_WAKE_WITH_ID_DELAY_NS));
  localparam logic [31:0] BLK_ERASE_CYC  = 32'(ERASE_CYCLES);
  localparam logic [31:0] CHIP_ERASE_CYC = 32'(FULL_ERASE_CYCLES);

  if (NUM_BLOCKS < 2 || NUM_BLOCKS > (1 << `FEPD_BLK_W)) begin : g_bad_blocks
    $error("fepd_top: NUM_BLOCKS out of range");
  end
  if (ERASE_CYCLES < 1 || FULL_ERASE_CYCLES < 1) begin : g_bad_times
    $error("fepd_top: erase cycle counts must be at least one");
  end

  // reset release
  logic [1:0]  rst_sync_q;
  logic        rst_n;

  // select synchroniser and edge history
  logic        cs_s1_q;
  logic        cs_s2_q;
  logic        cs_s3_q;
  logic        cs_rise;
  logic        cs_new;
  logic        seen_q;
  logic        seen_d;

  // frame seen by the link end
  fepd_frame_s frame;
  logic        len_op;
  logic        len_addr;
  logic        len_id;
  logic [4:0]  blk;

  // sequencing state
  fepd_state_e state_q;
  fepd_state_e state_d;
  logic [31:0] timer_q;
  logic [31:0] timer_d;
  logic        wel_q;
  logic        wel_d;
  logic        wip_q;
  logic        wip_d;
  logic        quiet_q;
  logic        quiet_d;
  logic        sleep_q;
  logic        sleep_d;
  logic        go_q;
  logic        go_d;
  logic        chip_q;
  logic        chip_d;
  logic [4:0]  eblk_q;
  logic [4:0]  eblk_d;
  logic        blk_prot;

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in)
      rst_sync_q <= 2'b00;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_n = rst_sync_q[1];

  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      cs_s1_q <= 1'b1;
      cs_s2_q <= 1'b1;
      cs_s3_q <= 1'b1;
    end else begin
      cs_s1_q <= cs_n_in;
      cs_s2_q <= cs_s1_q;
      cs_s3_q <= cs_s2_q;
    end
  end
  // frame fields are stable once select is high, the serial clock being idle
  assign cs_rise = cs_s2_q & ~cs_s3_q;

  // a select pulse with no clock edges leaves the old frame fields in place;
  // acting only on a new sequence bit keeps it from repeating that command
  assign cs_new = cs_rise & (frame.seq != seen_q);
  assign seen_d = cs_rise ? frame.seq : seen_q;

  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n)
      seen_q <= 1'b0;
    else
      seen_q <= seen_d;
  end

  fepd_link #(
    .MAKER_ID   (MAKER_ID),
    .PART_ID    (PART_ID)
  ) u_link (
    .sck_in     (sck_in),
    .cs_n_in    (cs_n_in),
    .rst_n_in   (rst_n),
    .io0_in     (io0_in),
    .io1_in     (io1_in),
    .sleep_in   (quiet_q),
    .busy_in    (wip_q),
    .frame_out  (frame),
    .io0_out    (io0_out),
    .io0_oe_out (io0_oe_out),
    .io1_out    (io1_out),
    .io1_oe_out (io1_oe_out)
  );

  // select must rise exactly after the last expected bit, except for a wake id read, which may run on past the address
  assign len_op   = (frame.len == `FEPD_LEN_OPCODE);
  assign len_addr = (frame.len == `FEPD_LEN_ADDR);
  assign len_id   = (frame.len >= `FEPD_LEN_ADDR);
  assign blk      = frame.addr[`FEPD_BLK_MSB:`FEPD_BLK_LSB];

  // top or bottom range of blocks covered by the protect level
  function automatic logic prot_hit(input logic [4:0] bp, input logic [4:0] b);
    int amt;
    int n;
    int bi;
    amt = int'(bp[`FEPD_BP_AMT_MSB:0]);
    bi  = int'(b);
    n   = 0;
    if (bp[`FEPD_BP_AMT_MSB:0] == `FEPD_BP_ALL)
      n = NUM_BLOCKS;
    else if (amt != 0)
      n = bp[`FEPD_BP_FINE] ? 1 : (1 << (amt - 1));
    if (n > NUM_BLOCKS)
      n = NUM_BLOCKS;
    if (bp[`FEPD_BP_BOTTOM])
      prot_hit = (bi < n);
    else
      prot_hit = (bi >= NUM_BLOCKS - n);
  endfunction

  assign blk_prot = prot_hit(protect_level_bits_in, blk);

  always_comb begin
    state_d = state_q;
    timer_d = (timer_q != 32'h0) ? timer_q - 32'h1 : 32'h0;
    wel_d   = wel_q;
    go_d    = 1'b0;
    chip_d  = chip_q;
    eblk_d  = eblk_q;
    case (state_q)
      FEPD_ST_IDLE: begin
        if (cs_new) begin
          case (frame.op)
            `FEPD_OP_WRITE_ENABLE: begin
              if (len_op)
                wel_d = 1'b1;
            end
            `FEPD_OP_BLOCK_ERASE: begin
              if (len_addr && wel_q && !blk_prot) begin
                state_d = FEPD_ST_ERASE;
                timer_d = BLK_ERASE_CYC - 32'h1;
                wel_d   = 1'b0;
                go_d    = 1'b1;
                chip_d  = 1'b0;
                eblk_d  = blk;
              end
            end
            `FEPD_OP_CHIP_ERASE_A, `FEPD_OP_CHIP_ERASE_B: begin
              if (len_op && wel_q && protect_level_bits_in == `FEPD_BP_NONE) begin
                state_d = FEPD_ST_ERASE;
                timer_d = CHIP_ERASE_CYC - 32'h1;
                wel_d   = 1'b0;
                go_d    = 1'b1;
                chip_d  = 1'b1;
                eblk_d  = 5'h00;
              end
            end
            `FEPD_OP_SLEEP: begin
              if (len_op) begin
                state_d = FEPD_ST_ENTER;
                timer_d = SLEEP_ENTRY_CYC - 32'h1;
              end
            end
            default: state_d = FEPD_ST_IDLE;
          endcase
        end
      end
      FEPD_ST_ERASE: begin
        // every command, sleep and wake included, is dropped here
        if (timer_q == 32'h0)
          state_d = FEPD_ST_IDLE;
      end
      FEPD_ST_ENTER: begin
        if (timer_q == 32'h0)
          state_d = FEPD_ST_SLEEP;
      end
      FEPD_ST_SLEEP: begin
        if (cs_new && frame.op == `FEPD_OP_WAKE_ID) begin
          if (len_op) begin
            state_d = FEPD_ST_WAKE;
            timer_d = WAKE_CYC - 32'h1;
          end else if (len_id) begin
            state_d = FEPD_ST_WAKE;
            timer_d = WAKE_ID_CYC - 32'h1;
          end
        end
      end
      FEPD_ST_WAKE: begin
        if (timer_q == 32'h0)
          state_d = FEPD_ST_IDLE;
      end
      default: begin
        state_d = FEPD_ST_IDLE;
        timer_d = 32'h0;
      end
    endcase
    wip_d   = (state_d == FEPD_ST_ERASE);
    quiet_d = (state_d == FEPD_ST_ENTER) || (state_d == FEPD_ST_SLEEP) ||
              (state_d == FEPD_ST_WAKE);
    sleep_d = (state_d == FEPD_ST_SLEEP);
  end

  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= FEPD_ST_IDLE;
      timer_q <= 32'h0;
      wel_q   <= 1'b0;
      wip_q   <= 1'b0;
      quiet_q <= 1'b0;
      sleep_q <= 1'b0;
      go_q    <= 1'b0;
      chip_q  <= 1'b0;
      eblk_q  <= 5'h00;
    end else begin
      state_q <= state_d;
      timer_q <= timer_d;
      wel_q   <= wel_d;
      wip_q   <= wip_d;
      quiet_q <= quiet_d;
      sleep_q <= sleep_d;
      go_q    <= go_d;
      chip_q  <= chip_d;
      eblk_q  <= eblk_d;
    end
  end

  assign write_in_progress_flag_out = wip_q;
  assign write_latch_flag_out       = wel_q;
  assign sleep_mode_out             = sleep_q;
  assign erase_go_out               = go_q;
  assign erase_chip_out             = chip_q;
  assign erase_block_out            = eblk_q;

endmodule

// *** design/fepd_defs.svh ***
// constants for the flash erase, power-down and id command block
// assumes one 25 MHz system clock; times are given in ns or ms
`ifndef FEPD_DEFS_SVH
`define FEPD_DEFS_SVH

// opcodes
`define FEPD_OP_WRITE_ENABLE  8'h06
`define FEPD_OP_BLOCK_ERASE   8'hD8
`define FEPD_OP_CHIP_ERASE_A  8'h60
`define FEPD_OP_CHIP_ERASE_B  8'hC7
`define FEPD_OP_SLEEP         8'hB9
`define FEPD_OP_WAKE_ID       8'hAB
`define FEPD_OP_MAKER_ID      8'h92
`define FEPD_OP_MAKER_ID_1L   8'h90

// frame lengths in serial clock edges
`define FEPD_LEN_OPCODE       6'h08
`define FEPD_LEN_ADDR         6'h20
`define FEPD_LEN_ADDR_DUAL    6'h14
`define FEPD_LEN_MAX          6'h3F
`define FEPD_ADDR_SWAP        24'h000001

// block index field of the address, 64KB blocks
`define FEPD_BLK_MSB          20
`define FEPD_BLK_LSB          16
`define FEPD_BLK_W            5

// protect level field layout
`define FEPD_BP_AMT_MSB       2
`define FEPD_BP_BOTTOM        3
`define FEPD_BP_FINE          4
`define FEPD_BP_ALL           3'h7
`define FEPD_BP_NONE          5'h00

// timing
`define FEPD_CLK_NS                 40
`define FEPD_SLEEP_ENTRY_DELAY_NS   3000
`define FEPD_WAKE_DELAY_NS          3000
`define FEPD_WAKE_WITH_ID_DELAY_NS  8000
`define FEPD_ERASE_CYCLE_TIME_MS    150
`define FEPD_FULL_ERASE_TIME_MS     8000
`define FEPD_CEIL_CYC(ns) (((ns) + `FEPD_CLK_NS - 1) / `FEPD_CLK_NS)
`define FEPD_MS_CYC(ms)   ((ms) * (1000000 / `FEPD_CLK_NS))

`endif

// *** design/fepd_pkg.sv ***
// types shared by the flash erase, power-down and id command block
// assumes the constants header is included by the design files
package fepd_pkg;

  typedef struct packed {
    logic [7:0]  op;
    logic [23:0] addr;
    logic [5:0]  len;
    logic        seq;
  } fepd_frame_s;

  typedef enum logic [2:0] {
    FEPD_ST_IDLE  = 3'b000,
    FEPD_ST_ERASE = 3'b001,
    FEPD_ST_ENTER = 3'b010,
    FEPD_ST_SLEEP = 3'b011,
    FEPD_ST_WAKE  = 3'b100
  } fepd_state_e;

endpackage

// *** design/fepd_link.sv ***
// serial link end: shifts in opcode and address, shifts out id bytes
// assumes it runs on the host's serial clock, which stops outside frames
`timescale 1ns/10ps
`include "fepd_defs.svh"
module fepd_link #(
  // identity defaults are arbitrary
  parameter logic [7:0] MAKER_ID = 8'h5A,
  parameter logic [7:0] PART_ID  = 8'h3C
) (
  input  wire logic                 sck_in,
  input  wire logic                 cs_n_in,
  input  wire logic                 rst_n_in,
  input  wire logic                 io0_in,
  input  wire logic                 io1_in,
  input  wire logic                 sleep_in,
  input  wire logic                 busy_in,
  output fepd_pkg::fepd_frame_s     frame_out,
  output logic                      io0_out,
  output logic                      io0_oe_out,
  output logic                      io1_out,
  output logic                      io1_oe_out
);
  import fepd_pkg::*;

  logic        frm_rst_n;
  logic [1:0]  sl_q, bz_q;
  logic        act_q, dual_q, oen_q, dual_d, oen_d;
  logic [5:0]  cnt_q, cnt_d;
  logic [31:0] sh_q, sh_d;
  logic [7:0]  op_q, op_d;
  logic [23:0] addr_q, addr_d;
  logic [3:0]  idx_q, idx_d, pos;
  logic [15:0] pair_q, pair_d;
  logic        o0_d, o1_d;
  logic        seq_q, seq_d;

  // act_q, dual_q, oen_q, idx_q and pair_q clear whenever select is high; op, address and count hold
  assign frm_rst_n = rst_n_in & ~cs_n_in;
  assign frame_out = '{op: op_q, addr: addr_q, len: cnt_q, seq: seq_q};

  always_comb begin
    cnt_d  = act_q ? ((cnt_q == `FEPD_LEN_MAX) ? cnt_q : cnt_q + 6'h01) : 6'h01;
    // toggles once for every frame that carries clock edges
    seq_d  = act_q ? seq_q : ~seq_q;
    if (!act_q)
      sh_d = {31'h0, io0_in};
    else if (dual_q)
      sh_d = {sh_q[29:0], io1_in, io0_in};
    else
      sh_d = {sh_q[30:0], io0_in};
    op_d   = (cnt_d == `FEPD_LEN_OPCODE) ? sh_d[7:0] : op_q;
    dual_d = dual_q | ((cnt_d == `FEPD_LEN_OPCODE) && sh_d[7:0] == `FEPD_OP_MAKER_ID);
    addr_d = addr_q;
    pair_d = pair_q;
    oen_d  = oen_q;
    idx_d  = oen_q ? (dual_q ? {1'b0, idx_q[2:0] + 3'h1} : idx_q + 4'h1) : 4'h0;
    if (act_q && (dual_q ? cnt_d == `FEPD_LEN_ADDR_DUAL : cnt_d == `FEPD_LEN_ADDR)) begin
      addr_d = sh_d[23:0];
      idx_d  = 4'h0;
      case (op_q)
        `FEPD_OP_WAKE_ID: begin
          oen_d  = ~bz_q[1];
          pair_d = {PART_ID, PART_ID};
        end
        `FEPD_OP_MAKER_ID, `FEPD_OP_MAKER_ID_1L: begin
          oen_d  = ~bz_q[1] & ~sl_q[1];
          pair_d = (sh_d[23:0] == `FEPD_ADDR_SWAP) ? {PART_ID, MAKER_ID}
                                                   : {MAKER_ID, PART_ID};
        end
        default: oen_d = 1'b0;
      endcase
    end
    pos  = dual_q ? {idx_q[2:0], 1'b0} : idx_q;
    o1_d = pair_q[4'hF - pos];
    o0_d = pair_q[4'hE - pos];
  end

  always_ff @(posedge sck_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sl_q   <= 2'b00;
      bz_q   <= 2'b00;
      cnt_q  <= 6'h00;
      sh_q   <= 32'h0;
      op_q   <= 8'h00;
      addr_q <= 24'h0;
      seq_q  <= 1'b0;
    end else begin
      sl_q   <= {sl_q[0], sleep_in};
      bz_q   <= {bz_q[0], busy_in};
      cnt_q  <= cnt_d;
      sh_q   <= sh_d;
      op_q   <= op_d;
      addr_q <= addr_d;
      seq_q  <= seq_d;
    end
  end

  always_ff @(posedge sck_in or negedge frm_rst_n) begin
    if (!frm_rst_n) begin
      act_q  <= 1'b0;
      dual_q <= 1'b0;
      oen_q  <= 1'b0;
      idx_q  <= 4'h0;
      pair_q <= 16'h0;
    end else begin
      act_q  <= 1'b1;
      dual_q <= dual_d;
      oen_q  <= oen_d;
      idx_q  <= idx_d;
      pair_q <= pair_d;
    end
  end

  // id bits change on the falling edge, msb first
  always_ff @(negedge sck_in or negedge frm_rst_n) begin
    if (!frm_rst_n) begin
      io0_out    <= 1'b0;
      io0_oe_out <= 1'b0;
      io1_out    <= 1'b0;
      io1_oe_out <= 1'b0;
    end else begin
      io1_out    <= oen_q & o1_d;
      io1_oe_out <= oen_q;
      io0_out    <= oen_q & dual_q & o0_d;
      io0_oe_out <= oen_q & dual_q;
    end
  end

endmodule

// *** dv/fepd_chk.sv ***
// checker for the erase, sleep and id command block
// assumes it is bound to fepd_top and sees only its ports
`timescale 1ns/10ps
module fepd_chk #(
  parameter int unsigned ERASE_CYCLES      = 20,
  parameter int unsigned FULL_ERASE_CYCLES = 400
) (
  input  wire logic       clk_sys_in,
  input  wire logic       nrst_in,
  input  wire logic       cs_n_in,
  input  wire logic       io0_oe_out,
  input  wire logic       io1_oe_out,
  input  wire logic [4:0] protect_level_bits_in,
  input  wire logic       write_in_progress_flag_out,
  input  wire logic       write_latch_flag_out,
  input  wire logic       sleep_mode_out,
  input  wire logic       erase_go_out,
  input  wire logic       erase_chip_out,
  input  wire logic [4:0] erase_block_out
);
  int unsigned busy_q;
  int unsigned busy_d;
  int unsigned lim;

  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!nrst_in);

  // cycles the busy flag has stood high
  always_comb begin
    busy_d = write_in_progress_flag_out ? busy_q + 1 : 0;
    lim    = erase_chip_out ? FULL_ERASE_CYCLES : ERASE_CYCLES;
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      busy_q <= 0;
    end else begin
      busy_q <= busy_d;
    end
  end

  go_pulse_a: assert property (erase_go_out |=> !erase_go_out)
    else $error("erase start pulse too long");
  busy_start_a: assert property ($rose(write_in_progress_flag_out) |->
    erase_go_out || $past(erase_go_out)) else $error("busy without erase start");
  busy_len_a: assert property ($fell(write_in_progress_flag_out) |->
    busy_q + 2 >= lim && busy_q <= lim + 2) else $error("erase length wrong");
  latch_clear_a: assert property (erase_go_out |=> !write_latch_flag_out [*3])
    else $error("write latch not cleared at erase");
  latch_end_a: assert property ($fell(write_in_progress_flag_out) |->
    !write_latch_flag_out) else $error("write latch set at erase end");
  go_latch_a: assert property (erase_go_out |->
    write_latch_flag_out || $past(write_latch_flag_out)) else $error("erase without latch");
  chip_prot_a: assert property (erase_go_out |=>
    !erase_chip_out || protect_level_bits_in == 5'h00) else $error("chip erase protected");
  sleep_busy_a: assert property (!(sleep_mode_out && write_in_progress_flag_out))
    else $error("asleep while busy");
  sleep_quiet_a: assert property (sleep_mode_out |->
    !erase_go_out && !$rose(write_latch_flag_out)) else $error("command acted in sleep");
  block_hold_a: assert property ($changed(erase_block_out) |->
    erase_go_out || $past(erase_go_out)) else $error("block index moved");
  id_oe_a: assert property (io1_oe_out |->
    !cs_n_in && !write_in_progress_flag_out) else $error("id driven when not allowed");
  dual_oe_a: assert property (io0_oe_out |-> io1_oe_out)
    else $error("line 0 driven alone");
endmodule

bind fepd_top fepd_chk #(.ERASE_CYCLES(ERASE_CYCLES), .FULL_ERASE_CYCLES(FULL_ERASE_CYCLES))
  i_chk (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .cs_n_in(cs_n_in),
  .io0_oe_out(io0_oe_out), .io1_oe_out(io1_oe_out),
  .protect_level_bits_in(protect_level_bits_in),
  .write_in_progress_flag_out(write_in_progress_flag_out),
  .write_latch_flag_out(write_latch_flag_out), .sleep_mode_out(sleep_mode_out),
  .erase_go_out(erase_go_out), .erase_chip_out(erase_chip_out),
  .erase_block_out(erase_block_out));

// *** dv/fepd_host.sv ***
// host model: drives select, serial clock and data lines of the link
// assumes the device answers on falling clock edges while selected
`timescale 1ns/10ps
module fepd_host (
  input  wire logic dev_io0_in,
  input  wire logic dev_io0_oe_in,
  input  wire logic dev_io1_in,
  input  wire logic dev_io1_oe_in,
  output logic      sck_out,
  output logic      cs_n_out,
  output logic      io0_out,
  output logic      io1_out
);
  logic h0 = 1'h0;
  logic h1 = 1'h0;

  // in the read phase a released line shows the inverse of its last level, never a stale bit
  assign io0_out = dev_io0_oe_in ? dev_io0_in : h0;
  assign io1_out = dev_io1_oe_in ? dev_io1_in : h1;

  initial begin
    sck_out = 1'h0;
    cs_n_out = 1'h1;
  end

  task automatic tick();
    #40;
    sck_out = 1'h1;
    #40;
    sck_out = 1'h0;
  endtask

  // clock stands low outside frames; bits change after each falling edge
  task automatic frame(input logic [7:0] op, input logic [23:0] addr, input int abits,
                       input logic dual, input int redges, output logic [31:0] rd);
    rd = 32'h0;
    #7;
    cs_n_out = 1'h0;
    for (int i = 0; i < 8; i++) begin
      h0 = op[7 - i];
      tick();
    end
    for (int i = 0; i < abits; i += dual ? 2 : 1) begin
      if (dual) begin
        {h1, h0} = addr[23 - i -: 2];
      end else begin
        h0 = addr[23 - i];
      end
      tick();
    end
    h0 = ~h0;
    h1 = ~h1;
    for (int i = 0; i < redges; i++) begin
      #40;
      sck_out = 1'h1;
      rd = dual ? {rd[29:0], io1_out, io0_out} : {rd[30:0], io1_out};
      #40;
      sck_out = 1'h0;
    end
    #20;
    cs_n_out = 1'h1;
    h0 = ~h0;
    h1 = ~h1;
    #200;
  endtask

  // select pulse with no clock edges
  task automatic blip();
    #7;
    cs_n_out = 1'h0;
    #100;
    cs_n_out = 1'h1;
    #200;
  endtask
endmodule

// *** dv/testbench.sv ***
// self-checking bench for the erase, sleep and id command block
// assumes the host model drives the link and the checker is bound in
`timescale 1ns/10ps
`include "fepd_defs.svh"
module testbench;
  localparam logic [7:0]  MID = 8'hA6; // arbitrary value
  localparam logic [7:0]  PID = 8'h19; // arbitrary value
  localparam logic [31:0] MP  = {MID, PID, MID, PID};
  localparam logic [31:0] PM  = {PID, MID, PID, MID};
  typedef struct packed {
    logic [7:0]  op;
    logic [23:0] addr;
    logic [5:0]  abits;
    logic        dual;
    logic [5:0]  redges;
    logic [4:0]  bp;
    logic        write_enable_cmd;
    logic        go;
    logic        chip;
    logic [31:0] rd;
  } fepd_row_s;
  fepd_row_s rows [17] = '{
    '{8'hD8, 24'h1EFFFF, 6'h18, 1'h0, 6'h00, 5'h00, 1'h1, 1'h1, 1'h0, 32'h0},
    '{8'hD8, 24'h000000, 6'h18, 1'h0, 6'h00, 5'h00, 1'h0, 1'h0, 1'h0, 32'h0},
    '{8'hD8, 24'h1F0000, 6'h18, 1'h0, 6'h00, 5'h01, 1'h1, 1'h0, 1'h0, 32'h0},
    '{8'hD8, 24'h1E0000, 6'h18, 1'h0, 6'h00, 5'h01, 1'h1, 1'h1, 1'h0, 32'h0},
    '{8'hD8, 24'h030000, 6'h10, 1'h0, 6'h00, 5'h00, 1'h1, 1'h0, 1'h0, 32'h0},
    '{8'hD8, 24'h000000, 6'h18, 1'h0, 6'h00, 5'h07, 1'h1, 1'h0, 1'h0, 32'h0},
    '{8'hD8, 24'h000000, 6'h18, 1'h0, 6'h00, 5'h09, 1'h1, 1'h0, 1'h0, 32'h0},
    '{8'hD8, 24'h1E1234, 6'h18, 1'h0, 6'h00, 5'h12, 1'h1, 1'h1, 1'h0, 32'h0},
    '{8'h60, 24'h000000, 6'h00, 1'h0, 6'h00, 5'h00, 1'h1, 1'h1, 1'h1, 32'h0},
    '{8'hC7, 24'h000000, 6'h00, 1'h0, 6'h00, 5'h01, 1'h1, 1'h0, 1'h0, 32'h0},
    '{8'h60, 24'h000000, 6'h08, 1'h0, 6'h00, 5'h00, 1'h1, 1'h0, 1'h0, 32'h0},
    '{8'hC7, 24'h000000, 6'h00, 1'h0, 6'h00, 5'h00, 1'h1, 1'h1, 1'h1, 32'h0},
    '{8'h90, 24'h000000, 6'h18, 1'h0, 6'h20, 5'h00, 1'h0, 1'h0, 1'h0, MP},
    '{8'h90, 24'h000001, 6'h18, 1'h0, 6'h20, 5'h00, 1'h0, 1'h0, 1'h0, PM},
    '{8'h92, 24'h000000, 6'h18, 1'h1, 6'h10, 5'h00, 1'h0, 1'h0, 1'h0, MP},
    '{8'h92, 24'h000001, 6'h18, 1'h1, 6'h10, 5'h00, 1'h0, 1'h0, 1'h0, PM},
    '{8'hAB, 24'h000000, 6'h18, 1'h0, 6'h20, 5'h00, 1'h0, 1'h0, 1'h0, {PID, PID, PID, PID}}};
  logic        clk_sys_in = 1'h0;
  logic        nrst_in    = 1'h0;
  logic [4:0]  bp         = 5'h00;
  logic        sck, cs_n, io0, io1, io0_o, io0_oe, io1_o, io1_oe;
  logic        write_in_progress_flag, write_latch_flag, slp, go, chip;
  logic [4:0]  blk;
  logic [31:0] rd;
  logic        go_seen    = 1'h0;
  logic        oe_seen    = 1'h0;
  int          fails      = 0;
  int          check_count = 0;
  int          cycles     = 0;

  fepd_top #(.ERASE_CYCLES(20), .FULL_ERASE_CYCLES(400), .MAKER_ID(MID), .PART_ID(PID)) i_dut (
    .clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .sck_in(sck), .cs_n_in(cs_n),
    .io0_in(io0), .io0_out(io0_o), .io0_oe_out(io0_oe), .io1_in(io1), .io1_out(io1_o),
    .io1_oe_out(io1_oe), .protect_level_bits_in(bp), .write_in_progress_flag_out(write_in_progress_flag),
    .write_latch_flag_out(write_latch_flag), .sleep_mode_out(slp), .erase_go_out(go),
    .erase_chip_out(chip), .erase_block_out(blk));
  fepd_host i_host (.dev_io0_in(io0_o), .dev_io0_oe_in(io0_oe), .dev_io1_in(io1_o),
    .dev_io1_oe_in(io1_oe), .sck_out(sck), .cs_n_out(cs_n), .io0_out(io0), .io1_out(io1));

  always #20 clk_sys_in = ~clk_sys_in;

  always @(posedge clk_sys_in) begin
    cycles++;
    if (go === 1'h1) go_seen = 1'h1;
    if (io1_oe === 1'h1) oe_seen = 1'h1;
    if (cycles == 20000) begin
      fails++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    if (fails == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wait_clk(input int n);
    repeat (n) @(negedge clk_sys_in);
  endtask

  task automatic fr(input logic [7:0] op, input logic [23:0] a, input int ab, input int re);
    i_host.frame(op, a, ab, 1'h0, re, rd);
  endtask

  task automatic run_row(input fepd_row_s r);
    int n;
    @(negedge clk_sys_in);
    bp = r.bp;
    if (r.write_enable_cmd) begin
      fr(`FEPD_OP_WRITE_ENABLE, 24'h0, 0, 0);
      wait_clk(8);
      check("latch set", write_latch_flag, 1'h1);
    end
    go_seen = 1'h0;
    i_host.frame(r.op, r.addr, int'(r.abits), r.dual, int'(r.redges), rd);
    wait_clk(8);
    check("erase start", go_seen, r.go);
    check("latch", write_latch_flag, r.write_enable_cmd & ~r.go);
    if (r.redges != 6'h00) check("id", rd, r.rd);
    if (r.go) begin
      check("busy", write_in_progress_flag, 1'h1);
      check("chip", chip, r.chip);
      if (!r.chip) check("block", blk, r.addr[20:16]);
      n = 0;
      while (write_in_progress_flag === 1'h1 && n < 1000) begin
        wait_clk(1);
        n++;
      end
      check("busy done", write_in_progress_flag, 1'h0);
    end
  endtask

  initial begin
    wait_clk(2);
    check("reset", {write_in_progress_flag, write_latch_flag, slp, go}, 4'h0);
    wait_clk(1);
    nrst_in = 1'h1;
    wait_clk(4);
    for (int i = 0; i < 17; i++) begin
      run_row(rows[i]);
    end
    fr(`FEPD_OP_SLEEP, 24'h0, 0, 0);
    wait_clk(50);
    check("early sleep", slp, 1'h0);
    wait_clk(40);
    check("sleep", slp, 1'h1);
    fr(`FEPD_OP_WRITE_ENABLE, 24'h0, 0, 0);
    wait_clk(8);
    check("latch asleep", write_latch_flag, 1'h0);
    oe_seen = 1'h0;
    fr(`FEPD_OP_MAKER_ID_1L, 24'h0, 24, 8);
    check("id asleep", oe_seen, 1'h0);
    fr(`FEPD_OP_WAKE_ID, 24'h0, 0, 0);
    wait_clk(8);
    check("woken", slp, 1'h0);
    wait_clk(80);
    fr(`FEPD_OP_SLEEP, 24'h0, 0, 0);
    wait_clk(90);
    fr(`FEPD_OP_WAKE_ID, 24'h0, 24, 16);
    check("wake id", rd, {16'h0000, PID, PID});
    check("woken by id", slp, 1'h0);
    wait_clk(210);
    fr(`FEPD_OP_WRITE_ENABLE, 24'h0, 0, 0);
    fr(`FEPD_OP_CHIP_ERASE_A, 24'h0, 0, 0);
    fr(`FEPD_OP_SLEEP, 24'h0, 0, 0);
    oe_seen = 1'h0;
    fr(`FEPD_OP_WAKE_ID, 24'h0, 24, 8);
    check("id while busy", oe_seen, 1'h0);
    check("busy kept", write_in_progress_flag, 1'h1);
    wait_clk(400);
    check("no sleep", slp, 1'h0);
    check("chip done", write_in_progress_flag, 1'h0);
    bp = 5'h01;
    fr(`FEPD_OP_WRITE_ENABLE, 24'h0, 0, 0);
    fr(`FEPD_OP_BLOCK_ERASE, 24'h1F0000, 24, 0);
    wait_clk(8);
    bp = 5'h00;
    go_seen = 1'h0;
    i_host.blip();
    wait_clk(8);
    check("stale frame", go_seen, 1'h0);
    fr(`FEPD_OP_SLEEP, 24'h0, 0, 0);
    wait_clk(90);
    nrst_in = 1'h0;
    wait_clk(3);
    check("reset in sleep", {write_in_progress_flag, write_latch_flag, slp}, 3'h0);
    nrst_in = 1'h1;
    wait_clk(4);
    fr(`FEPD_OP_WRITE_ENABLE, 24'h0, 0, 0);
    wait_clk(8);
    check("standby", write_latch_flag, 1'h1);
    give_verdict();
  end
endmodule
